/* File: include/vts_params.svh */
/*
 * constants of the valve travel supervisor: register byte offsets,
 * reset values, range limits and percent scaling.
 * assumes travel, set point and percent figures other than the accumulator, its
 * point and its deadband are signed 16-bit values in steps of 0.01 % of ranged
 * travel (10000 = 100 %).
 */
//
// Contract
// - rise of target limited so full range takes at least opening time.
// - fall of target limited so full range takes at least closing time.
// - polling address 0..15 under revision 5, 0..63 under revision 7.
// - only the master type that took unit out may return it.
// - set point passes first-order lag; zero time constant bypasses it.
// - travel change adds to accumulator only when beyond its deadband.
// - deadband reference reset at each increment; width 0..100 %.
// - host may write accumulator; writing zero clears the total.
// - accumulator alert while above point; clears only on rewrite below.
// - four level alerts hi, lo, hi-hi, lo-lo, thresholds -25..125 %.
// - level alert clears only once travel is back by alert deadband.
// - deviation alert after deviation exceeds point longer than set time.
// - deviation alert holds until deviation falls below its point.
// - deviation time accepted from 1 to 60 seconds inclusive.
// - travel beyond cutoff forces drive to max or min per zero action.
// - rate limits suspended while travel lies beyond a cutoff.
// - target clamped between low and high travel limits.
`ifndef VTS_PARAMS_SVH
`define VTS_PARAMS_SVH

`define VTS_A_CTRL 8'h00
`define VTS_A_OPEN 8'h04
`define VTS_A_CLOSE 8'h08
`define VTS_A_LAG 8'h0C
`define VTS_A_LIM_HI 8'h10
`define VTS_A_LIM_LO 8'h14
`define VTS_A_CUT_HI 8'h18
`define VTS_A_CUT_LO 8'h1C
`define VTS_A_ACC_DB 8'h20
`define VTS_A_ACC 8'h24
`define VTS_A_ACC_HI 8'h28
`define VTS_A_ACC_PT 8'h2C
`define VTS_A_ACC_PT_HI 8'h30
`define VTS_A_TA0 8'h34
`define VTS_A_TA_DB 8'h44
`define VTS_A_DEV_PT 8'h48
`define VTS_A_DEV_T 8'h4C
`define VTS_A_POLL 8'h50
`define VTS_A_SVC 8'h54
`define VTS_A_STAT 8'h58
`define VTS_A_TGT 8'h5C
`define VTS_A_IRQ_ST 8'h60
`define VTS_A_IRQ_MASK 8'h64

`define VTS_FULL 16'h2710
`define VTS_PCT_MIN 16'hF63C
`define VTS_PCT_MAX 16'h30D4
`define VTS_RATE_MAX 16'h0190
`define VTS_DEV_T_MIN 16'h0001
`define VTS_DEV_T_MAX 16'h003C
`define VTS_POLL_MAX5 8'h0F
`define VTS_POLL_MAX7 8'h3F
`define VTS_CRD_CAP 32'h4000_0000

`define VTS_RST_LIM_HI 16'h30D4
`define VTS_RST_LIM_LO 16'hF63C
`define VTS_RST_CUT_HI 16'h7FFF
`define VTS_RST_CUT_LO 16'h8000
`define VTS_RST_TA_HI 16'h30D4
`define VTS_RST_TA_LO 16'hF63C
`define VTS_RST_TA_DB 16'h01F4
`define VTS_RST_ACC_DB 16'h0064
`define VTS_RST_ACC_PT 40'hFF_FFFF_FFFF
`define VTS_RST_DEV_PT 16'h01F4
`define VTS_RST_DEV_T 16'h000A

`endif

/* File: include/vts_pkg.sv */
/*
 * types of the valve travel supervisor.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package vts_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_FILT,
        PH_RATE
    } vts_phase_e;

    typedef struct packed {
        logic acc;
        logic dev;
        logic ll;
        logic hh;
        logic lo;
        logic hi;
    } vts_alert_s;
endpackage

/* File: rtl/vts_top.sv */
/*
 * valve travel supervisor: set point filter, rate limit, travel limits,
 * cutoffs, travel accumulator, level and deviation alerts, polling
 * address and service ownership, register port with interrupt.
 * assumes sp_in, travel_in and tick are synchronous to clk and that tick
 * pulses for one cycle, far less often than the stepping engine needs.
 */
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "vts_params.svh"

module vts_top #(
    parameter int TICK_HZ = 100
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic signed [15:0] sp_in,
    input wire logic signed [15:0] travel_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    output logic signed [15:0] target,
    output logic drive_max,
    output logic drive_min,
    output vts_pkg::vts_alert_s alerts,
    output logic in_service,
    output logic [5:0] poll_addr
);
    if (TICK_HZ < 1 || TICK_HZ > 1000) begin : g_chk
        $error("TICK_HZ out of range");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    function automatic logic pct_ok(input logic [31:0] d);
        pct_ok = $signed(d[15:0]) >= $signed(`VTS_PCT_MIN) &&
                 $signed(d[15:0]) <= $signed(`VTS_PCT_MAX);
    endfunction

    function automatic logic signed [15:0] clamp(
        input logic signed [15:0] v,
        input logic signed [15:0] hi,
        input logic signed [15:0] lo);
        clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    // configuration
    logic zsa_r;
    logic [15:0] open_t_r, close_t_r, lag_t_r, acc_db_r, dev_t_r;
    logic signed [15:0] lim_hi_r, lim_lo_r, cut_hi_r, cut_lo_r;
    logic signed [15:0] ta_db_r, dev_pt_r;
    logic signed [15:0] ta_pt_r [0:3];
    logic [39:0] acc_pt_r;
    logic [5:0] mask_r;
    logic wsel_acc;
    assign wsel_acc = wr && hit(addr, `VTS_A_ACC);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zsa_r <= 1'b0;
            open_t_r <= 16'h0000;
            close_t_r <= 16'h0000;
            lag_t_r <= 16'h0000;
            lim_hi_r <= `VTS_RST_LIM_HI;
            lim_lo_r <= `VTS_RST_LIM_LO;
            cut_hi_r <= `VTS_RST_CUT_HI;
            cut_lo_r <= `VTS_RST_CUT_LO;
            acc_db_r <= `VTS_RST_ACC_DB;
            acc_pt_r <= `VTS_RST_ACC_PT;
            ta_pt_r[0] <= `VTS_RST_TA_HI;
            ta_pt_r[1] <= `VTS_RST_TA_LO;
            ta_pt_r[2] <= `VTS_RST_TA_HI;
            ta_pt_r[3] <= `VTS_RST_TA_LO;
            ta_db_r <= `VTS_RST_TA_DB;
            dev_pt_r <= `VTS_RST_DEV_PT;
            dev_t_r <= `VTS_RST_DEV_T;
            mask_r <= 6'h00;
        end else if (wr) begin
            case (addr)
                `VTS_A_CTRL: zsa_r <= wdata[0];
                `VTS_A_OPEN: begin
                    if (wdata[15:0] <= `VTS_RATE_MAX)
                        open_t_r <= wdata[15:0];
                end
                `VTS_A_CLOSE: begin
                    if (wdata[15:0] <= `VTS_RATE_MAX)
                        close_t_r <= wdata[15:0];
                end
                `VTS_A_LAG: lag_t_r <= wdata[15:0];
                `VTS_A_LIM_HI: lim_hi_r <= wdata[15:0];
                `VTS_A_LIM_LO: lim_lo_r <= wdata[15:0];
                `VTS_A_CUT_HI: cut_hi_r <= wdata[15:0];
                `VTS_A_CUT_LO: cut_lo_r <= wdata[15:0];
                `VTS_A_ACC_DB: begin
                    if (wdata[15:0] <= `VTS_FULL)
                        acc_db_r <= wdata[15:0];
                end
                `VTS_A_ACC_PT: acc_pt_r[31:0] <= wdata;
                `VTS_A_ACC_PT_HI: acc_pt_r[39:32] <= wdata[7:0];
                `VTS_A_TA_DB: begin
                    if (pct_ok(wdata))
                        ta_db_r <= wdata[15:0];
                end
                `VTS_A_DEV_PT: begin
                    if (wdata[15:0] <= `VTS_FULL)
                        dev_pt_r <= wdata[15:0];
                end
                `VTS_A_DEV_T: begin
                    if (wdata[15:0] >= `VTS_DEV_T_MIN &&
                        wdata[15:0] <= `VTS_DEV_T_MAX)
                        dev_t_r <= wdata[15:0];
                end
                `VTS_A_IRQ_MASK: mask_r <= wdata[5:0];
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (addr == `VTS_A_TA0 + 8'(4 * i) && pct_ok(wdata))
                            ta_pt_r[i] <= wdata[15:0];
                    end
                end
            endcase
        end
    end

    // polling address and service ownership
    logic rev7_r, oos_pri_r, in_service_r;
    logic [5:0] poll_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rev7_r <= 1'b0;
            poll_r <= 6'h00;
        end else if (wr && hit(addr, `VTS_A_POLL)) begin
            if (wdata[7:0] <= (wdata[8] ? `VTS_POLL_MAX7 : `VTS_POLL_MAX5)) begin
                rev7_r <= wdata[8];
                poll_r <= wdata[5:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_service_r <= 1'b1;
            oos_pri_r <= 1'b1;
        end else if (wr && hit(addr, `VTS_A_SVC)) begin
            if (wdata[0] && in_service_r) begin
                in_service_r <= 1'b0;
                oos_pri_r <= wdata[1];
            end else if (!wdata[0] && !in_service_r && wdata[1] == oos_pri_r) begin
                in_service_r <= 1'b1;
            end
        end
    end

    // set point chain: filter, then rate-limited, clamped target
    vts_pkg::vts_phase_e ph_r;
    logic signed [15:0] filt_r, target_r, goal;
    logic signed [31:0] facc_r, lag_n;
    logic [31:0] crd_r, up_n, dn_n, step_n;
    logic cut_any_r, up;
    assign goal = clamp(filt_r, lim_hi_r, lim_lo_r);
    assign lag_n = $signed(32'(lag_t_r) * 32'(TICK_HZ));
    assign up_n = 32'(open_t_r) * 32'(TICK_HZ);
    assign dn_n = 32'(close_t_r) * 32'(TICK_HZ);
    assign up = target_r < goal;
    assign step_n = up ? up_n : dn_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_r <= vts_pkg::PH_IDLE;
            filt_r <= 16'h0000;
            facc_r <= 32'h0000_0000;
            target_r <= 16'h0000;
            crd_r <= 32'h0000_0000;
        end else begin
            case (ph_r)
                vts_pkg::PH_IDLE: begin
                    target_r <= clamp(target_r, lim_hi_r, lim_lo_r);
                    if (tick && in_service_r) begin
                        ph_r <= vts_pkg::PH_FILT;
                        if (crd_r < `VTS_CRD_CAP)
                            crd_r <= crd_r + 32'(`VTS_FULL);
                        if (lag_t_r == 16'h0000) begin
                            filt_r <= sp_in;
                            facc_r <= 32'h0000_0000;
                        end else begin
                            facc_r <= facc_r + 32'(sp_in) - 32'(filt_r);
                        end
                    end
                end
                vts_pkg::PH_FILT: begin
                    if (lag_t_r != 16'h0000 && facc_r >= lag_n) begin
                        filt_r <= filt_r + 16'sh0001;
                        facc_r <= facc_r - lag_n;
                    end else if (lag_t_r != 16'h0000 && facc_r <= -lag_n) begin
                        filt_r <= filt_r - 16'sh0001;
                        facc_r <= facc_r + lag_n;
                    end else begin
                        ph_r <= vts_pkg::PH_RATE;
                    end
                end
                vts_pkg::PH_RATE: begin
                    if (target_r == goal) begin
                        crd_r <= 32'h0000_0000;
                        ph_r <= vts_pkg::PH_IDLE;
                    end else if (cut_any_r || step_n == 32'h0000_0000) begin
                        target_r <= goal;
                        crd_r <= 32'h0000_0000;
                        ph_r <= vts_pkg::PH_IDLE;
                    end else if (crd_r >= step_n) begin
                        target_r <= up ? target_r + 16'sh0001
                                       : target_r - 16'sh0001;
                        crd_r <= crd_r - step_n;
                    end else begin
                        ph_r <= vts_pkg::PH_IDLE;
                    end
                end
                default: ph_r <= vts_pkg::PH_IDLE;
            endcase
        end
    end

    // cutoffs force the drive
    logic drive_max_r, drive_min_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cut_any_r <= 1'b0;
            drive_max_r <= 1'b0;
            drive_min_r <= 1'b0;
        end else if (tick) begin
            cut_any_r <= travel_in > cut_hi_r || travel_in < cut_lo_r;
            drive_max_r <= zsa_r ? travel_in < cut_lo_r
                                 : travel_in > cut_hi_r;
            drive_min_r <= zsa_r ? travel_in > cut_hi_r
                                 : travel_in < cut_lo_r;
        end
    end

    // travel accumulator
    logic [39:0] acc_r;
    logic signed [15:0] ref_r;
    logic signed [16:0] acc_d;
    logic [15:0] acc_mag;
    logic acc_al_r;
    assign acc_d = 17'(travel_in) - 17'(ref_r);
    assign acc_mag = acc_d[16] ? 16'(-acc_d) : acc_d[15:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_r <= 40'h00_0000_0000;
            ref_r <= 16'h0000;
        end else if (wsel_acc) begin
            acc_r <= {8'h00, wdata};
        end else if (tick && acc_mag > acc_db_r) begin
            acc_r <= acc_r + 40'(acc_mag);
            ref_r <= travel_in;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_al_r <= 1'b0;
        end else if (wsel_acc && {8'h00, wdata} < acc_pt_r) begin
            acc_al_r <= 1'b0;
        end else if (acc_r > acc_pt_r) begin
            acc_al_r <= 1'b1;
        end
    end

    // travel level alerts: 0 hi, 1 lo, 2 hi-hi, 3 lo-lo
    logic [3:0] ta_al_r;
    for (genvar i = 0; i < 4; i++) begin : g_ta
        localparam bit HI = (i % 2) == 0;
        logic signed [16:0] rel;
        assign rel = HI ? 17'(ta_pt_r[i]) - 17'(ta_db_r)
                        : 17'(ta_pt_r[i]) + 17'(ta_db_r);
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                ta_al_r[i] <= 1'b0;
            end else if (tick) begin
                if (HI ? travel_in > ta_pt_r[i] : travel_in < ta_pt_r[i])
                    ta_al_r[i] <= 1'b1;
                else if (HI ? 17'(travel_in) <= rel : 17'(travel_in) >= rel)
                    ta_al_r[i] <= 1'b0;
            end
        end
    end

    // deviation alert
    logic signed [16:0] dev_d;
    logic [15:0] dev_mag;
    logic [31:0] dev_cnt_r, dev_n;
    logic dev_al_r;
    assign dev_d = 17'(target_r) - 17'(travel_in);
    assign dev_mag = dev_d[16] ? 16'(-dev_d) : dev_d[15:0];
    assign dev_n = 32'(dev_t_r) * 32'(TICK_HZ);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dev_cnt_r <= 32'h0000_0000;
            dev_al_r <= 1'b0;
        end else if (tick) begin
            if (dev_mag > dev_pt_r) begin
                if (dev_cnt_r >= dev_n)
                    dev_al_r <= 1'b1;
                else
                    dev_cnt_r <= dev_cnt_r + 32'h0000_0001;
            end else begin
                dev_cnt_r <= 32'h0000_0000;
                if (dev_mag < dev_pt_r)
                    dev_al_r <= 1'b0;
            end
        end
    end

    // interrupt status: rising alert edges, write one to clear
    vts_pkg::vts_alert_s al_now, al_d_r;
    logic [5:0] ist_r, ev;
    logic irq_r;
    assign al_now = '{acc: acc_al_r, dev: dev_al_r, ll: ta_al_r[3],
                      hh: ta_al_r[2], lo: ta_al_r[1], hi: ta_al_r[0]};
    assign ev = al_now & ~al_d_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            al_d_r <= '0;
            ist_r <= 6'h00;
            irq_r <= 1'b0;
        end else begin
            al_d_r <= al_now;
            if (wr && hit(addr, `VTS_A_IRQ_ST))
                ist_r <= (ist_r & ~wdata[5:0]) | ev;
            else
                ist_r <= ist_r | ev;
            irq_r <= |(ist_r & mask_r);
        end
    end

    // read port
    logic [31:0] rdata_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (!rd) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            case (addr)
                `VTS_A_CTRL: rdata_r <= {31'h0, zsa_r};
                `VTS_A_OPEN: rdata_r <= {16'h0000, open_t_r};
                `VTS_A_CLOSE: rdata_r <= {16'h0000, close_t_r};
                `VTS_A_LAG: rdata_r <= {16'h0000, lag_t_r};
                `VTS_A_LIM_HI: rdata_r <= 32'(lim_hi_r);
                `VTS_A_LIM_LO: rdata_r <= 32'(lim_lo_r);
                `VTS_A_CUT_HI: rdata_r <= 32'(cut_hi_r);
                `VTS_A_CUT_LO: rdata_r <= 32'(cut_lo_r);
                `VTS_A_ACC_DB: rdata_r <= {16'h0000, acc_db_r};
                `VTS_A_ACC: rdata_r <= acc_r[31:0];
                `VTS_A_ACC_HI: rdata_r <= {24'h00_0000, acc_r[39:32]};
                `VTS_A_ACC_PT: rdata_r <= acc_pt_r[31:0];
                `VTS_A_ACC_PT_HI: rdata_r <= {24'h00_0000, acc_pt_r[39:32]};
                `VTS_A_TA_DB: rdata_r <= 32'(ta_db_r);
                `VTS_A_DEV_PT: rdata_r <= 32'(dev_pt_r);
                `VTS_A_DEV_T: rdata_r <= {16'h0000, dev_t_r};
                `VTS_A_POLL: rdata_r <= {23'h00_0000, rev7_r, 2'h0, poll_r};
                `VTS_A_SVC: rdata_r <= {30'h0, oos_pri_r, in_service_r};
                `VTS_A_STAT: rdata_r <= {24'h00_0000, drive_min_r,
                                         drive_max_r, al_now};
                `VTS_A_TGT: rdata_r <= 32'(target_r);
                `VTS_A_IRQ_ST: rdata_r <= {26'h000_0000, ist_r};
                `VTS_A_IRQ_MASK: rdata_r <= {26'h000_0000, mask_r};
                `VTS_A_TA0: rdata_r <= 32'(ta_pt_r[0]);
                8'h38: rdata_r <= 32'(ta_pt_r[1]);
                8'h3C: rdata_r <= 32'(ta_pt_r[2]);
                8'h40: rdata_r <= 32'(ta_pt_r[3]);
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
    assign target = target_r;
    assign drive_max = drive_max_r;
    assign drive_min = drive_min_r;
    assign alerts = al_now;
    assign in_service = in_service_r;
    assign poll_addr = poll_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_rate_up_step: assert property (
        (ph_r == vts_pkg::PH_RATE && up && !cut_any_r && open_t_r != 0)
        |=> target_r <= $past(target_r) + 16'sh0001)
        else $error("target rose faster than one step");
    a_rate_dn_step: assert property (
        (ph_r == vts_pkg::PH_RATE && target_r > goal && !cut_any_r &&
         close_t_r != 0) |=> target_r >= $past(target_r) - 16'sh0001)
        else $error("target fell faster than one step");
    a_poll_rev5_range: assert property (
        !rev7_r |-> poll_r <= 6'h0F)
        else $error("revision 5 polling address above 15");
    a_svc_same_master: assert property (
        $rose(in_service_r) |-> $past(wr && addr == `VTS_A_SVC &&
                                      wdata[1] == oos_pri_r))
        else $error("service returned by other master type");
    a_lag_bypass: assert property (
        (ph_r == vts_pkg::PH_IDLE && tick && in_service_r && lag_t_r == 0)
        |=> filt_r == $past(sp_in))
        else $error("zero lag did not bypass filter");
    a_acc_ref_move: assert property (
        (acc_r > $past(acc_r) && !$past(wsel_acc))
        |-> ref_r == $past(travel_in))
        else $error("reference not reset on increment");
    a_acc_alert_hold: assert property (
        (acc_al_r && !wsel_acc) |=> acc_al_r)
        else $error("accumulator alert cleared without rewrite");
    a_cut_hi_drive: assert property (
        (tick && travel_in > cut_hi_r && !zsa_r) |=> drive_max_r && !drive_min_r)
        else $error("high cutoff did not force drive maximum");
    a_dev_alert_hold: assert property (
        $fell(dev_al_r) |-> $past(tick && dev_mag < dev_pt_r))
        else $error("deviation alert cleared early");
    a_ta_hi_clear: assert property (
        $fell(ta_al_r[0]) |-> $past(17'(travel_in) <= g_ta[0].rel))
        else $error("high alert cleared inside deadband");
endmodule

/* File: test/vts_host.sv */
/*
 * control system model: hands over a new set point with its sample tick.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module vts_host (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic signed [15:0] sp_req,
    output logic tick,
    output logic signed [15:0] sp_in
);
    // set point and tick leave together, one tick for each cycle that req is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
            sp_in <= 16'h0000;
        end else begin
            tick <= req;
            if (req) begin
                sp_in <= sp_req;
            end
        end
    end
endmodule

/* File: test/tb.sv */
/*
 * self-checking bench of the valve travel supervisor.
 * assumes the design package, parameter header and host model.
 */
`timescale 1ns/1ns
`include "vts_params.svh"
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic signed [15:0] sp_q = 16'h0000;
    logic signed [15:0] trv = 16'h0000;
    logic signed [15:0] sp_in, target, e, t0;
    logic [31:0] rdata;
    logic tick, irq, drive_max, drive_min, in_service;
    logic [5:0] poll_addr;
    vts_pkg::vts_alert_s alerts;
    int error_cnt = 0;
    int compares = 0;
    always #10 clk = ~clk;
    vts_host vts_host_i (.clk(clk), .rstn(rstn), .req(req), .sp_req(sp_q),
        .tick(tick), .sp_in(sp_in));
    vts_top #(.TICK_HZ(1000)) vts_top_i (.clk(clk), .rstn(rstn),
        .tick(tick), .sp_in(sp_in), .travel_in(trv), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .target(target), .drive_max(drive_max), .drive_min(drive_min),
        .alerts(alerts), .in_service(in_service), .poll_addr(poll_addr));
    function automatic logic signed [15:0] clamp(logic signed [15:0] v);
        if (v > 16'sh1F40) begin
            return 16'sh1F40;
        end
        return (v < 16'sh03E8) ? 16'sh03E8 : v;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, x);
    endtask
    task automatic tk(input logic signed [15:0] sp, input logic signed [15:0] t);
        @(posedge clk);
        req <= 1'b1;
        sp_q <= sp;
        trv <= t;
        @(posedge clk);
        req <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hD2F559A5));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk({in_service, poll_addr, alerts, irq, target}, 32'h2000_0000);
        rreg(`VTS_A_LIM_HI, 32'h30D4);
        rreg(`VTS_A_DEV_T, 32'h000A);
        rreg(8'hFC, 32'h0);
        wreg(`VTS_A_LIM_HI, 32'h1F40);
        wreg(`VTS_A_LIM_LO, 32'h03E8);
        for (int i = 0; i < 6; i++) begin
            e = (i == 0) ? 16'h0000 : 16'($urandom % 10001);
            tk(e, 16'h0000);
            chk(target, clamp(e));
        end
        wreg(`VTS_A_POLL, 32'h14);
        wreg(`VTS_A_POLL, 32'h114);
        chk(poll_addr, 32'h14);
        wreg(`VTS_A_POLL, 32'h140);
        chk(poll_addr, 32'h14);
        wreg(`VTS_A_POLL, 32'h0);
        wreg(`VTS_A_SVC, 32'h3);
        wreg(`VTS_A_SVC, 32'h0);
        rreg(`VTS_A_SVC, 32'h2);
        wreg(`VTS_A_SVC, 32'h2);
        rreg(`VTS_A_SVC, 32'h3);
        wreg(`VTS_A_ACC_PT, 32'h5);
        wreg(`VTS_A_ACC_PT_HI, 32'h0);
        wreg(`VTS_A_IRQ_MASK, 32'h20);
        tk(16'h1388, 16'h012C);
        rreg(`VTS_A_ACC, 32'h12C);
        chk({alerts.acc, irq}, 2'b11);
        wreg(`VTS_A_ACC, 32'h0);
        tk(16'h1388, 16'h015E);
        rreg(`VTS_A_ACC, 32'h0);
        chk(alerts.acc, 1'b0);
        rreg(`VTS_A_IRQ_ST, 32'h20);
        wreg(`VTS_A_IRQ_ST, 32'h20);
        rreg(`VTS_A_IRQ_ST, 32'h0);
        chk(irq, 1'b0);
        tk(16'h1388, 16'h01C2);
        rreg(`VTS_A_ACC, 32'h96);
        wreg(`VTS_A_TA0, 32'h1388);
        tk(16'h1388, 16'h1770);
        chk(alerts.hi, 1'b1);
        tk(16'h1388, 16'h12C0);
        chk(alerts.hi, 1'b1);
        tk(16'h1388, 16'h1130);
        chk(alerts.hi, 1'b0);
        wreg(`VTS_A_OPEN, 32'h1);
        wreg(`VTS_A_CLOSE, 32'h1);
        t0 = target;
        tk(16'h1F40, 16'h1130);
        chk(target > t0 && target <= t0 + 16'sh000A, 1'b1);
        t0 = target;
        tk(16'h03E8, 16'h1130);
        chk(target < t0 && target >= t0 - 16'sh000A, 1'b1);
        wreg(`VTS_A_CUT_HI, 32'h2328);
        for (int z = 0; z < 2; z++) begin
            wreg(`VTS_A_CTRL, 32'(z));
            tk(16'h1388, 16'h251C);
            chk({drive_max, drive_min}, (z == 0) ? 2'b10 : 2'b01);
        end
        wreg(`VTS_A_DEV_T, 32'h3D);
        rreg(`VTS_A_DEV_T, 32'h000A);
        wreg(`VTS_A_DEV_T, 32'h1);
        wreg(`VTS_A_SVC, 32'h3);
        tk(16'h1388, 16'h1388);
        chk(alerts.dev, 1'b0);
        @(posedge clk);
        req <= 1'b1;
        trv <= 16'h1770;
        repeat (990) @(posedge clk);
        #1 chk(alerts.dev, 1'b0);
        repeat (20) @(posedge clk);
        #1 chk(alerts.dev, 1'b1);
        @(posedge clk);
        req <= 1'b0;
        tk(16'h1388, 16'h157C);
        chk(alerts.dev, 1'b1);
        tk(16'h1388, 16'h1388);
        chk(alerts.dev, 1'b0);
        finish_test();
    end
endmodule
